// File: common/hcp_pkg.sv
/*
 * shared constants of the host command port: word layout, byte counts,
 * apb register map of the host end, interrupt bits.
 * assumes a single pclk domain shared by both ends.
 */
package hcp_pkg;
   // -------------------------------------------------------------
   // port word layout
   // -------------------------------------------------------------
   localparam int HCP_WORD_W = 16;
   localparam int HCP_BYTE_W = 8;
   localparam int HCP_CD_BIT = 8;       // command/data flag position
   localparam int HCP_IE_BIT = 9;       // interrupt permission (host to board)
   localparam int HCP_BUSY_BIT = 9;     // busy (board to host)
   localparam int HCP_STB_BIT = 15;     // host byte strobe toggle
   localparam int HCP_ACK_BIT = 15;     // board byte toggle
   // -------------------------------------------------------------
   // message lengths and execute cycles
   // -------------------------------------------------------------
   localparam int HCP_CMD_LEN = 5;
   localparam int HCP_RPT_LEN = 6;
   localparam int HCP_EXEC_CYCLES = 4;
   // -------------------------------------------------------------
   // host apb registers
   // -------------------------------------------------------------
   localparam logic [7:0] HCP_OFF_OUT = 8'h00;   // host to board word shadow
   localparam logic [7:0] HCP_OFF_IN = 8'h04;    // board to host word
   localparam logic [7:0] HCP_OFF_STAT = 8'h08;  // sticky events, w1c
   localparam logic [7:0] HCP_OFF_MASK = 8'h0C;
   localparam logic [7:0] HCP_OFF_BITOP = 8'h10; // bit field write, single bit set/clear/test
   localparam int HCP_EV_NB = 0;        // board went not busy
   localparam int HCP_EV_RB = 1;        // board ack toggled: byte taken or report byte shown
   localparam logic [1:0] HCP_MASK_RST = 2'h0;
   localparam logic [15:0] HCP_WORD_RST = 16'h0000;
endpackage

// File: common/hcp_if.sv
/*
 * the two 16-bit port words between host end and board end.
 * assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface hcp_if;
   logic [15:0] out_word;   // host to board
   logic [15:0] in_word;    // board to host
   modport host (output out_word, input in_word);
   modport board (input out_word, output in_word);
endinterface
`default_nettype wire

// File: src/hcp_field_ops.sv
/*
 * bit field merge for the port word: writes 1..16 bits at a start bit,
 * or sets/clears one bit, and tests one bit.
 * assumes same-clock inputs, purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module hcp_field_ops
   import hcp_pkg::*;
(
   // operands
   input wire logic [15:0] cur_word,
   input wire logic [15:0] wr_data,
   input wire logic [3:0] start_bit,
   input wire logic [4:0] bit_count,
   input wire logic single_op,
   input wire logic single_val,
   // results
   output logic [15:0] new_word,
   output logic tested_bit
);
   logic [15:0] field_mask;
   logic [15:0] shifted;
   // mask of bit_count bits from start_bit, count clamped to 1..16
   always_comb begin
      field_mask = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if ((i >= int'(start_bit)) && (i < int'(start_bit) + int'(bit_count)))
            field_mask[i] = 1'b1;
      end
      if (single_op || (bit_count == 5'h00)) begin
         field_mask = 16'h0001 << start_bit;
      end
   end
   assign shifted = single_op ? {16{single_val}} : (wr_data << start_bit);
   assign new_word = (cur_word & ~field_mask) | (shifted & field_mask);
   assign tested_bit = cur_word[start_bit];
endmodule
`default_nettype wire

// File: src/hcp_board.sv
/*
 * board end of the host command port: takes five command bytes and any data
 * bytes sent between the first and the fifth, runs the command, returns a six byte completion report.
 * assumes the host toggles the strobe bit once per byte and waits
 * for the ack toggle before the next; single pclk domain.
 */
// How it works
// - one 16-bit word each way
// - host writes 1..16 bits, bit ops
// - out word: high control, low byte
// - in word: high status, low byte
// - out bit 8 marks command or data
// - in bit 8 marks data or status
// - commands are five bytes long
// - report is six bytes long
// - report: echo, four status, completion
// - host checks busy before commanding
// - host sets interrupt permission when busy
// - busy to idle raises interrupt when permitted
// - host sends five command bytes, flag set
// - data follows with flag cleared; code takes data bytes only before the fifth command byte
`timescale 1ns/1ps
`default_nettype none
module hcp_board
   import hcp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // host port
   hcp_if.board port,
   // user side: accepted data bytes and report status
   output logic data_valid,
   output logic [7:0] data_byte,
   input wire logic [31:0] status_in,
   input wire logic [7:0] completion_in,
   output logic host_irq
);
   typedef enum logic [1:0] {
      HCPB_IDLE = 2'b00,
      HCPB_CMD = 2'b01,
      HCPB_EXEC = 2'b10,
      HCPB_RPT = 2'b11
   } hcpb_state_e;

   hcpb_state_e state_reg;
   logic [15:0] sync1_reg, sync2_reg;
   logic stb_seen_reg, ack_reg, busy_reg, irq_reg, dv_reg;
   logic [2:0] cnt_reg;
   logic [7:0] echo_reg, out_byte_reg, dbyte_reg;
   logic [HCP_BYTE_W*4-1:0] stat_reg;
   logic [7:0] comp_reg;
   logic rpt_flag_reg;
   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   wire new_byte = sync2_reg[HCP_STB_BIT] != stb_seen_reg;
   wire is_cmd = sync2_reg[HCP_CD_BIT];
   wire [7:0] low_byte = sync2_reg[7:0];
   wire irq_ok = sync2_reg[HCP_IE_BIT];
   wire busy_next = state_reg != HCPB_IDLE;
   wire [7:0] rpt_byte = (cnt_reg == 3'd0) ? echo_reg :
      (cnt_reg == 3'd5) ? comp_reg : stat_reg[8*(4-int'(cnt_reg)) +: 8];

   // host word comes from another board: two stage sync
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= HCP_WORD_RST;
         sync2_reg <= HCP_WORD_RST;
      end else begin
         sync1_reg <= port.out_word;
         sync2_reg <= sync1_reg;
      end
   end

   // command, execute and report sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= HCPB_IDLE;
         stb_seen_reg <= 1'b0;
         ack_reg <= 1'b0;
         cnt_reg <= 3'd0;
         echo_reg <= 8'h00;
         out_byte_reg <= 8'h00;
         dbyte_reg <= 8'h00;
         dv_reg <= 1'b0;
         stat_reg <= 32'h0000_0000;
         comp_reg <= 8'h00;
         rpt_flag_reg <= 1'b0;
      end else begin
         dv_reg <= 1'b0;
         if (new_byte) begin
            stb_seen_reg <= ~stb_seen_reg;
         end
         case (state_reg)
            HCPB_IDLE: begin
               rpt_flag_reg <= 1'b0;
               if (new_byte && is_cmd) begin
                  echo_reg <= low_byte;
                  cnt_reg <= 3'd1;
                  ack_reg <= ~ack_reg;
                  state_reg <= HCPB_CMD;
               end
            end
            HCPB_CMD: begin
               if (new_byte) begin
                  ack_reg <= ~ack_reg;
                  if (!is_cmd) begin
                     dbyte_reg <= low_byte;
                     dv_reg <= 1'b1;
                  end else if (cnt_reg == 3'(HCP_CMD_LEN - 1)) begin
                     cnt_reg <= 3'd0;
                     state_reg <= HCPB_EXEC;
                  end else begin
                     cnt_reg <= cnt_reg + 3'd1;
                  end
               end
            end
            HCPB_EXEC: begin
               if (cnt_reg == 3'(HCP_EXEC_CYCLES - 1)) begin
                  stat_reg <= status_in;
                  comp_reg <= completion_in;
                  cnt_reg <= 3'd0;
                  state_reg <= HCPB_RPT;
               end else begin
                  cnt_reg <= cnt_reg + 3'd1;
               end
            end
            HCPB_RPT: begin
               // each host strobe consumes the byte shown
               if (!rpt_flag_reg) begin
                  out_byte_reg <= rpt_byte;
                  rpt_flag_reg <= 1'b1;
                  ack_reg <= ~ack_reg;
               end else if (new_byte) begin
                  rpt_flag_reg <= 1'b0;
                  if (cnt_reg == 3'(HCP_RPT_LEN - 1)) begin
                     state_reg <= HCPB_IDLE;
                  end else begin
                     cnt_reg <= cnt_reg + 3'd1;
                  end
               end
            end
            default: state_reg <= HCPB_IDLE;
         endcase
      end
   end

   // busy flag and interrupt on busy to idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
         if (busy_reg && !busy_next && irq_ok) begin
            irq_reg <= 1'b1;
         end else if (!irq_ok || busy_next) begin
            irq_reg <= 1'b0;
         end
      end
   end

   // board to host word
   assign port.in_word = {ack_reg, 5'b00000, busy_reg, rpt_flag_reg,
                          out_byte_reg};
   assign data_valid = dv_reg;
   assign data_byte = dbyte_reg;
   assign host_irq = irq_reg;
endmodule
`default_nettype wire

// File: src/hcp_host.sv
/*
 * host end: apb slave that shadows the host to board word and lets
 * software write bit fields, set/clear/test bits and read the board word.
 * assumes a single pclk; apb3 signalling, zero wait states.
 */
`timescale 1ns/1ps
`default_nettype none
module hcp_host
   import hcp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt to software
   output logic irq,
   // board port
   hcp_if.host port
);
   logic [15:0] out_reg, in_s1_reg, in_s2_reg, in_prev_reg;
   logic [1:0] stat_reg, mask_reg;
   logic [31:0] rdata_reg;
   logic irq_reg, err_reg;
   logic [15:0] merged;
   logic tested;
   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   wire acc = psel && !penable;
   // a write lands at the access edge, where the master samples pready high
   wire wr = psel && penable && pwrite;
   wire hit_out = paddr == HCP_OFF_OUT;
   wire hit_in = paddr == HCP_OFF_IN;
   wire hit_stat = paddr == HCP_OFF_STAT;
   wire hit_mask = paddr == HCP_OFF_MASK;
   wire hit_bit = paddr == HCP_OFF_BITOP;
   wire mapped = hit_out | hit_in | hit_stat | hit_mask | hit_bit;
   wire ev_nb = in_prev_reg[HCP_BUSY_BIT] && !in_s2_reg[HCP_BUSY_BIT];
   wire ev_rb = in_prev_reg[HCP_ACK_BIT] != in_s2_reg[HCP_ACK_BIT];
   wire [1:0] ev = {ev_rb, ev_nb};

   // field layout: [15:0] data, [19:16] start, [24:20] count,
   // [28] single bit op, [29] value
   hcp_field_ops u_ops (
      .cur_word(out_reg),
      .wr_data(pwdata[15:0]),
      .start_bit(pwdata[19:16]),
      .bit_count(pwdata[24:20]),
      .single_op(pwdata[28]),
      .single_val(pwdata[29]),
      .new_word(merged),
      .tested_bit(tested)
   );

   // registers; read data and error are fetched in setup, so the single
   // access cycle already shows them; writes wait for the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg <= HCP_WORD_RST;
         in_s1_reg <= HCP_WORD_RST;
         in_s2_reg <= HCP_WORD_RST;
         in_prev_reg <= HCP_WORD_RST;
         stat_reg <= 2'b00;
         mask_reg <= HCP_MASK_RST;
         rdata_reg <= 32'h0000_0000;
         irq_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         in_s1_reg <= port.in_word;
         in_s2_reg <= in_s1_reg;
         in_prev_reg <= in_s2_reg;
         err_reg <= acc && !mapped;
         if (wr && hit_out) out_reg <= pwdata[15:0];
         if (wr && hit_bit) out_reg <= merged;
         if (wr && hit_mask) mask_reg <= pwdata[1:0];
         // set beats clear
         stat_reg <= ev | (stat_reg & ~((wr && hit_stat) ? pwdata[1:0] : 2'b00));
         irq_reg <= |(stat_reg & mask_reg);
         if (acc && !pwrite) begin
            rdata_reg <= hit_out ? {16'h0000, out_reg} :
                         hit_in ? {16'h0000, in_s2_reg} :
                         hit_stat ? {30'h0000_0000, stat_reg} :
                         hit_mask ? {30'h0000_0000, mask_reg} :
                         hit_bit ? {31'h0000_0000, tested} : 32'h0000_0000;
         end
      end
   end

   assign prdata = rdata_reg;
   assign pready = 1'b1;
   assign pslverr = err_reg;
   assign irq = irq_reg;
   assign port.out_word = out_reg;
endmodule
`default_nettype wire

// File: test/hcp_chk_sva.sv
/*
 * checker on the two port words between host end and board end.
 * assumes one pclk domain, async active low reset, sits beside hcp_if.
 */
`timescale 1ns/1ps
`default_nettype none
module hcp_chk
   import hcp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // port words
   input wire logic [15:0] out_word,
   input wire logic [15:0] in_word
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic busy_reg;
   logic first_reg;
   logic [7:0] cmd_reg;
   // keep the command byte that started the busy period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         first_reg <= 1'b0;
         cmd_reg <= 8'h00;
      end else begin
         busy_reg <= in_word[HCP_BUSY_BIT];
         if (in_word[HCP_BUSY_BIT] && !busy_reg) begin
            cmd_reg <= out_word[7:0];
            first_reg <= 1'b1;
         end else if (in_word[HCP_CD_BIT]) begin
            first_reg <= 1'b0;
         end
      end
   end
   property p_rpt_busy;
      in_word[8] |-> in_word[9];
   endproperty
   a_rpt_busy: assert property (p_rpt_busy) else $error("report byte while idle");
   property p_idle_clean;
      $fell(in_word[9]) |-> !in_word[8];
   endproperty
   a_idle_clean: assert property (p_idle_clean) else $error("report flag left up");
   property p_busy_hold;
      $rose(in_word[9]) |=> in_word[9] [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
   property p_busy_cmd;
      $rose(in_word[9]) |-> out_word[HCP_CD_BIT];
   endproperty
   a_busy_cmd: assert property (p_busy_cmd) else $error("busy without command");
   property p_rpt_ack;
      $rose(in_word[8]) |-> $changed(in_word[15]);
   endproperty
   a_rpt_ack: assert property (p_rpt_ack) else $error("report without ack");
   property p_rpt_hold;
      in_word[8] && $changed(in_word[7:0]) |-> $changed(in_word[15]);
   endproperty
   a_rpt_hold: assert property (p_rpt_hold) else $error("report byte changed");
   property p_echo;
      in_word[8] && first_reg |-> in_word[7:0] == cmd_reg;
   endproperty
   a_echo: assert property (p_echo) else $error("first report byte not echo");
   property p_ack_gap;
      $changed(in_word[15]) |=> $stable(in_word[15]);
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("ack toggled twice");
endmodule
`default_nettype wire

// File: test/tb_top.sv
/*
 * bench: apb master on the host end, user side of the board end.
 * assumes hcp_pkg, hcp_if and both ends compiled first; one pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top
   import hcp_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err, data_valid, host_irq;
   logic [7:0] data_byte;
   logic [31:0] status_in = 32'h1122_3344;
   logic [7:0] completion_in = 8'h5A;
   logic [15:0] ow = 16'h0000;
   logic ack_last = 1'b0;
   logic [7:0] ex [6];
   logic [7:0] dq [$];
   int bad_count = 0;
   int checks_done = 0;
   hcp_if u_hcp_if ();
   hcp_host u_hcp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .port(u_hcp_if.host));
   hcp_board u_hcp_board (.pclk(pclk), .presetn(presetn), .port(u_hcp_if.board),
      .data_valid(data_valid), .data_byte(data_byte), .status_in(status_in),
      .completion_in(completion_in), .host_irq(host_irq));
   hcp_chk u_hcp_chk (.pclk(pclk), .presetn(presetn), .out_word(u_hcp_if.out_word),
      .in_word(u_hcp_if.in_word));
   // clock and capture of accepted data bytes
   always #4 pclk = ~pclk;
   always @(posedge pclk) if (data_valid === 1'b1) dq.push_back(data_byte);
   task end_sim;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // one apb transfer, read data and error kept in rd and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         bad_count++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // poll the board word until its ack bit toggles
   task automatic wait_ack;
      int n;
      n = 0;
      do begin
         apb(1'b0, HCP_OFF_IN, 32'h0000_0000);
         n++;
      end while (rd[15] === ack_last && n < 40);
      if (rd[15] === ack_last) begin
         bad_count++;
         end_sim();
      end
      ack_last = rd[15];
   endtask
   // place a byte with its flag, then toggle the strobe
   task automatic send(input logic f, input logic [7:0] b);
      ow[8] = f;
      ow[7:0] = b;
      apb(1'b1, HCP_OFF_OUT, {16'h0000, ow});
      ow[15] = ~ow[15];
      apb(1'b1, HCP_OFF_OUT, {16'h0000, ow});
      wait_ack();
   endtask
   // bit op then readback of the host word
   task automatic bop(input logic [31:0] d, input logic [15:0] e);
      apb(1'b1, HCP_OFF_BITOP, d);
      apb(1'b0, HCP_OFF_OUT, 32'h0000_0000);
      `CHK(rd[15:0], e)
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      ex = '{8'hC3, status_in[31:24], status_in[23:16], status_in[15:8], status_in[7:0],
         completion_in};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, HCP_OFF_OUT, 32'h0000_0000);
      `CHK(rd[15:0], HCP_WORD_RST);
      apb(1'b0, HCP_OFF_IN, 32'h0000_0000);
      `CHK(rd[15:0], 16'h0000);
      apb(1'b0, HCP_OFF_MASK, 32'h0000_0000);
      `CHK(rd[1:0], HCP_MASK_RST);
      apb(1'b0, 8'h40, 32'h0000_0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000});
      bop(32'h0044_0005, 16'h0050);
      bop(32'h3009_0000, 16'h0250);
      bop(32'h1004_0000, 16'h0240);
      apb(1'b0, HCP_OFF_BITOP, 32'h0006_0000);
      `CHK(rd[0], 1'b1);
      apb(1'b0, HCP_OFF_BITOP, 32'h0004_0000);
      `CHK(rd[0], 1'b0);
      bop(32'h0100_0000, 16'h0000);
      send(1'b1, 8'hC3);
      apb(1'b0, HCP_OFF_IN, 32'h0000_0000);
      `CHK(rd[9], 1'b1);
      ow[9] = 1'b1;
      send(1'b1, 8'h01);
      send(1'b1, 8'h02);
      send(1'b1, 8'h03);
      send(1'b0, 8'hD1);
      send(1'b0, 8'hD2);
      send(1'b1, 8'h04);
      `CHK({dq[0], dq[1]}, 16'hD1D2);
      for (int i = 0; i < 6; i++) begin
         wait_ack();
         `CHK(rd[9:0], {2'b11, ex[i]});
         ow[15] = ~ow[15];
         apb(1'b1, HCP_OFF_OUT, {16'h0000, ow});
      end
      for (int n = 0; n < 20 && rd[9] !== 1'b0; n++) apb(1'b0, HCP_OFF_IN, 32'h0000_0000);
      `CHK(rd[9:8], 2'b00);
      for (int n = 0; n < 20 && host_irq !== 1'b1; n++) @(posedge pclk);
      `CHK(host_irq, 1'b1);
      apb(1'b0, HCP_OFF_STAT, 32'h0000_0000);
      `CHK({irq, rd[1:0]}, 3'b011);
      apb(1'b1, HCP_OFF_MASK, 32'h0000_0001);
      apb(1'b1, HCP_OFF_STAT, 32'h0000_0002);
      `CHK(irq, 1'b1);
      apb(1'b1, HCP_OFF_STAT, 32'h0000_0001);
      apb(1'b0, HCP_OFF_STAT, 32'h0000_0000);
      `CHK({irq, rd[1:0]}, 3'b000);
      end_sim();
   end
endmodule
`default_nettype wire
